// File: logic/lfs_params.svh
// lfs_params.svh: offsets, field positions, reset values and sizes of the lazy state control
// assumes inclusion by bare name from design files that also import lfs_pkg
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// register byte offsets on the AXI4-Lite slave
`define LFS_OFF_CTRL0 8'h00
`define LFS_OFF_CTRL4 8'h04
`define LFS_OFF_XFE_LO 8'h08
`define LFS_OFF_XFE_HI 8'h0C
`define LFS_OFF_BITMAP 8'h10
`define LFS_OFF_FAULTS 8'h14

// field positions
`define LFS_TS_BIT 3
`define LFS_OSX_BIT 18
`define LFS_FEAT_EXT_STATE_SAVE_INSTR_BIT 26
`define LFS_FEAT_OS_EXT_STATE_ENABLE_BIT 27
`define LFS_X87_BIT 0

// reset values
`define LFS_CTRL0_RST 32'h0000_0000
`define LFS_CTRL4_RST 32'h0000_0000
`define LFS_XFE_RST 64'h0000_0000_0000_0001

// components that hold floating-point or vector state
`define LFS_FPVEC_MASK 64'h0000_0000_0000_0003

// feature leaves and save-area sizes in bytes
`define LFS_LEAF_FEAT 32'h0000_0001
`define LFS_LEAF_XSTATE 32'h0000_000D
`define LFS_LEGACY_BYTES 32'h0000_0200
`define LFS_HDR_BYTES 32'h0000_0040

// AXI response codes
`define LFS_RESP_OKAY 2'b00
`define LFS_RESP_SLVERR 2'b10

`endif

// File: logic/lfs_pkg.sv
// lfs_pkg: types of the lazy state control
// assumes nothing of its surroundings
package lfs_pkg;

  typedef enum logic [3:0] {
    LFS_OP_NONE = 4'b0000,
    LFS_OP_FPVEC = 4'b0001,
    LFS_OP_PACKED_INT = 4'b0010,
    LFS_OP_CRC = 4'b0011,
    LFS_OP_POPULATION_COUNT_INSTR = 4'b0100,
    LFS_OP_MOV_CR0 = 4'b0101,
    LFS_OP_MOV_CR4 = 4'b0110,
    LFS_OP_CLEAR_TASK_SWITCHED_INSTR = 4'b0111,
    LFS_OP_TASK_SWITCH = 4'b1000,
    LFS_OP_FEATURE_ID = 4'b1001,
    LFS_OP_XFE_READ = 4'b1010,
    LFS_OP_XFE_WRITE = 4'b1011,
    LFS_OP_SAVE = 4'b1100,
    LFS_OP_RESTORE = 4'b1101
  } lfs_op_e;

  typedef logic [63:0] lfs_comp_t;

endpackage : lfs_pkg

// File: logic/lfs_comp_if.sv
// lfs_comp_if: component selection between the control and the component unit
// assumes both ends run in the same clock domain
`timescale 1ns/1ns
interface lfs_comp_if #(
  parameter int NCOMP = 64
);
  logic [NCOMP-1:0] sel;
  logic [NCOMP-1:0] enabled;
  logic [NCOMP-1:0] bitmap;
  logic [NCOMP-1:0] store;
  logic [NCOMP-1:0] load;
  logic [NCOMP-1:0] init;

  modport unit (
    input sel,
    input enabled,
    input bitmap,
    output store,
    output load,
    output init
  );

  modport ctrl (
    output sel,
    output enabled,
    output bitmap,
    input store,
    input load,
    input init
  );
endinterface : lfs_comp_if

// File: logic/lfs_comp_unit.sv
// lfs_comp_unit: per-component store, load or initialise decision for save and restore
// assumes mask, enable and header bitmap are stable while the control samples the result
`timescale 1ns/1ns
module lfs_comp_unit
  import lfs_pkg::*;
#(
  parameter int NCOMP = 64
) (
  // selection in, decisions out
  lfs_comp_if.unit cif
);

  logic [NCOMP-1:0] active;

  // only components both requested and enabled take part
  assign active = cif.sel & cif.enabled;

  // each stored component gets its bitmap bit set, same positions as the enable reg
  assign cif.store = active;

  // a set bitmap bit loads from the image, a clear one initialises
  assign cif.load = active & cif.bitmap;
  assign cif.init = active & ~cif.bitmap;

endmodule : lfs_comp_unit

// File: logic/lfs_ctrl.sv
// lfs_ctrl: lazy floating-point/vector state trap and extended state save/restore control
// assumes a decoded instruction stream synchronous to clock_i and an AXI4-Lite master
// Functional notes
// - task_switched_flag set: fp, packed-int, vector ops fault before executing
// - crc_accumulate and population_count never fault on task_switched_flag
// - hardware task switch sets task_switched_flag
// - move to machine_control_reg0 sets or clears task_switched_flag explicitly
// - clear_task_switched_instr clears task_switched_flag; handler issues it after swap
// - save area: 512 legacy bytes, 64 byte header, then component areas
// - feature leaf 1 ecx bit 26 reports extended save support
// - feature leaf 1 ecx bit 27 reports os_ext_state_enable
// - os_ext_state_enable is bit 18 of machine_control_reg4
// - enable register readable at any ring, writable at ring 0 only
// - save and restore act only on components selected by the mask
// - save sets bitmap bit for each component written
// - bitmap bit positions match enable register bit positions
// - header bitmap at offset 0; reserved bytes 8..23 must be zero
// - restore loads selected enabled component when its bitmap bit is 1
// - restore initialises selected enabled component when its bitmap bit is 0
// - task_switched_flag is bit 3 of machine_control_reg0
// - save or restore touching fp or vector state faults while flag set
// - writing 0 to enable register bit 0 is a general protection fault
`timescale 1ns/1ns
`include "lfs_params.svh"
module lfs_ctrl
  import lfs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit EXT_STATE_SAVE_INSTR_SUPPORTED = 1'b1,
  parameter logic [63:0] XFE_SUPPORTED = 64'h0000_0000_0000_0003,
  parameter logic [31:0] EXT_AREA_BYTES = 32'h0000_0100
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // decoded instruction in
  input wire logic instr_valid_i,
  input wire lfs_op_e instr_op_i,
  input wire logic [1:0] instr_ring_i,
  input wire logic [63:0] instr_data_i,
  input wire logic [63:0] hdr_bitmap_i,
  input wire logic [127:0] hdr_rsvd_i,
  // completion out
  output logic done_o,
  output logic nm_fault_o,
  output logic gp_fault_o,
  output logic [63:0] result_o,
  output logic [63:0] store_mask_o,
  output logic [63:0] load_mask_o,
  output logic [63:0] init_mask_o,
  output logic [63:0] bitmap_o,
  output logic [31:0] area_bytes_o,
  // state out
  output logic task_switched_o,
  output logic os_ext_enable_o,
  output logic [63:0] xfe_o
);

  logic [31:0] ctrl0_r;
  logic [31:0] ctrl4_r;
  logic [63:0] xfe_r;
  logic [63:0] last_bitmap_r;
  logic [15:0] nm_cnt_r;
  logic [15:0] gp_cnt_r;
  logic aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_bad;
  logic [31:0] wr_merged;
  logic [31:0] wr_old;
  logic ts;
  logic nm_nxt;
  logic gp_nxt;
  logic [63:0] fpvec_touch;
  logic [63:0] result_nxt;

  lfs_comp_if #(.NCOMP(64)) cif ();

  lfs_comp_unit #(.NCOMP(64)) u_comp (
    .cif (cif.unit)
  );

  assign cif.sel = instr_data_i;
  assign cif.enabled = xfe_r;
  assign cif.bitmap = hdr_bitmap_i;

  assign ts = ctrl0_r[`LFS_TS_BIT];
  assign fpvec_touch = instr_data_i & xfe_r & `LFS_FPVEC_MASK;

  // fault decision for the instruction offered this cycle
  always_comb
  begin
    nm_nxt = 1'b0;
    gp_nxt = 1'b0;
    case (instr_op_i)
      LFS_OP_FPVEC, LFS_OP_PACKED_INT:
        nm_nxt = ts;
      LFS_OP_CRC, LFS_OP_POPULATION_COUNT_INSTR:
        nm_nxt = 1'b0;
      LFS_OP_MOV_CR0, LFS_OP_CLEAR_TASK_SWITCHED_INSTR:
        gp_nxt = (instr_ring_i != 2'b00);
      LFS_OP_MOV_CR4:
        gp_nxt = (instr_ring_i != 2'b00) ||
                 (instr_data_i[`LFS_OSX_BIT] && !EXT_STATE_SAVE_INSTR_SUPPORTED);
      LFS_OP_XFE_WRITE:
        gp_nxt = (instr_ring_i != 2'b00) ||
                 !instr_data_i[`LFS_X87_BIT] ||
                 ((instr_data_i & ~XFE_SUPPORTED) != 64'h0000_0000_0000_0000);
      LFS_OP_SAVE:
        nm_nxt = ts && (fpvec_touch != 64'h0000_0000_0000_0000);
      LFS_OP_RESTORE:
      begin
        nm_nxt = ts && (fpvec_touch != 64'h0000_0000_0000_0000);
        gp_nxt = !nm_nxt && (hdr_rsvd_i != 128'h0);
      end
      default:
      begin
        nm_nxt = 1'b0;
        gp_nxt = 1'b0;
      end
    endcase
  end

  // result value of reads and feature queries
  always_comb
  begin
    result_nxt = 64'h0000_0000_0000_0000;
    case (instr_op_i)
      LFS_OP_XFE_READ:
        result_nxt = xfe_r;
      LFS_OP_FEATURE_ID:
        if (instr_data_i[31:0] == `LFS_LEAF_FEAT)
        begin
          result_nxt[`LFS_FEAT_EXT_STATE_SAVE_INSTR_BIT] = EXT_STATE_SAVE_INSTR_SUPPORTED;
          result_nxt[`LFS_FEAT_OS_EXT_STATE_ENABLE_BIT] = ctrl4_r[`LFS_OSX_BIT];
        end
        else if (instr_data_i[31:0] == `LFS_LEAF_XSTATE)
        begin
          result_nxt[31:0] = `LFS_LEGACY_BYTES + `LFS_HDR_BYTES + EXT_AREA_BYTES;
          result_nxt[63:32] = XFE_SUPPORTED[31:0];
        end
      default:
        result_nxt = 64'h0000_0000_0000_0000;
    endcase
  end

  // AXI write channel: address and data held in either order
  assign s_axi_awready_o = !aw_held_r;
  assign s_axi_wready_o = !w_held_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  always_comb
  begin
    wr_old = 32'h0000_0000;
    case (aw_addr_r)
      `LFS_OFF_CTRL0: wr_old = ctrl0_r;
      `LFS_OFF_CTRL4: wr_old = ctrl4_r;
      `LFS_OFF_XFE_LO: wr_old = xfe_r[31:0];
      `LFS_OFF_XFE_HI: wr_old = xfe_r[63:32];
      default: wr_old = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++)
    begin
      wr_merged[b*8 +: 8] = w_strb_r[b] ? w_data_r[b*8 +: 8] : wr_old[b*8 +: 8];
    end
    case (aw_addr_r)
      `LFS_OFF_CTRL0, `LFS_OFF_CTRL4:
        wr_bad = 1'b0;
      `LFS_OFF_XFE_LO:
        wr_bad = !wr_merged[`LFS_X87_BIT] ||
                 ((wr_merged & ~XFE_SUPPORTED[31:0]) != 32'h0000_0000);
      `LFS_OFF_XFE_HI:
        wr_bad = ((wr_merged & ~XFE_SUPPORTED[63:32]) != 32'h0000_0000);
      default:
        wr_bad = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid_i && !w_held_r)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `LFS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_bad ? `LFS_RESP_SLVERR : `LFS_RESP_OKAY;
    end
    else if (s_axi_bready_i)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // control register 0; a set from a task switch wins over any clear
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl0_r <= `LFS_CTRL0_RST;
    else
    begin
      if (wr_fire && aw_addr_r == `LFS_OFF_CTRL0)
        ctrl0_r <= wr_merged;
      if (instr_valid_i && !gp_nxt && instr_op_i == LFS_OP_MOV_CR0)
        ctrl0_r <= instr_data_i[31:0];
      if (instr_valid_i && !gp_nxt && instr_op_i == LFS_OP_CLEAR_TASK_SWITCHED_INSTR)
        ctrl0_r[`LFS_TS_BIT] <= 1'b0;
      if (instr_valid_i && instr_op_i == LFS_OP_TASK_SWITCH)
        ctrl0_r[`LFS_TS_BIT] <= 1'b1;
    end
  end

  // control register 4 with the os enable bit
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl4_r <= `LFS_CTRL4_RST;
    else if (instr_valid_i && !gp_nxt && instr_op_i == LFS_OP_MOV_CR4)
      ctrl4_r <= instr_data_i[31:0];
    else if (wr_fire && aw_addr_r == `LFS_OFF_CTRL4)
      ctrl4_r <= wr_merged;
  end

  // extended feature enable register, written only when no fault
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      xfe_r <= `LFS_XFE_RST;
    else if (instr_valid_i && !gp_nxt && instr_op_i == LFS_OP_XFE_WRITE)
      xfe_r <= instr_data_i;
    else if (wr_fire && !wr_bad && aw_addr_r == `LFS_OFF_XFE_LO)
      xfe_r[31:0] <= wr_merged;
    else if (wr_fire && !wr_bad && aw_addr_r == `LFS_OFF_XFE_HI)
      xfe_r[63:32] <= wr_merged;
  end

  // completion outputs, one cycle after the instruction is offered
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_o <= 1'b0;
      nm_fault_o <= 1'b0;
      gp_fault_o <= 1'b0;
      result_o <= 64'h0000_0000_0000_0000;
      store_mask_o <= 64'h0000_0000_0000_0000;
      load_mask_o <= 64'h0000_0000_0000_0000;
      init_mask_o <= 64'h0000_0000_0000_0000;
      bitmap_o <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      done_o <= instr_valid_i;
      nm_fault_o <= instr_valid_i && nm_nxt;
      gp_fault_o <= instr_valid_i && gp_nxt;
      // a faulting instruction produces no result and no state movement
      if (instr_valid_i && !nm_nxt && !gp_nxt)
      begin
        result_o <= result_nxt;
        store_mask_o <= (instr_op_i == LFS_OP_SAVE) ? cif.store : 64'h0000_0000_0000_0000;
        bitmap_o <= (instr_op_i == LFS_OP_SAVE) ? cif.store : 64'h0000_0000_0000_0000;
        load_mask_o <= (instr_op_i == LFS_OP_RESTORE) ? cif.load : 64'h0000_0000_0000_0000;
        init_mask_o <= (instr_op_i == LFS_OP_RESTORE) ? cif.init : 64'h0000_0000_0000_0000;
      end
      else
      begin
        result_o <= 64'h0000_0000_0000_0000;
        store_mask_o <= 64'h0000_0000_0000_0000;
        bitmap_o <= 64'h0000_0000_0000_0000;
        load_mask_o <= 64'h0000_0000_0000_0000;
        init_mask_o <= 64'h0000_0000_0000_0000;
      end
    end
  end

  // status kept for software: last saved bitmap and fault counts
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      last_bitmap_r <= 64'h0000_0000_0000_0000;
      nm_cnt_r <= 16'h0000;
      gp_cnt_r <= 16'h0000;
    end
    else if (instr_valid_i)
    begin
      if (!nm_nxt && !gp_nxt && instr_op_i == LFS_OP_SAVE)
        last_bitmap_r <= cif.store;
      if (nm_nxt)
        nm_cnt_r <= nm_cnt_r + 16'h0001;
      if (gp_nxt)
        gp_cnt_r <= gp_cnt_r + 16'h0001;
    end
  end

  // AXI read channel
  assign s_axi_arready_o = !rvalid_r;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `LFS_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= `LFS_RESP_OKAY;
      case (s_axi_araddr_i)
        `LFS_OFF_CTRL0: rdata_r <= ctrl0_r;
        `LFS_OFF_CTRL4: rdata_r <= ctrl4_r;
        `LFS_OFF_XFE_LO: rdata_r <= xfe_r[31:0];
        `LFS_OFF_XFE_HI: rdata_r <= xfe_r[63:32];
        `LFS_OFF_BITMAP: rdata_r <= last_bitmap_r[31:0];
        `LFS_OFF_FAULTS: rdata_r <= {gp_cnt_r, nm_cnt_r};
        default:
        begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `LFS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  assign area_bytes_o = `LFS_LEGACY_BYTES + `LFS_HDR_BYTES + EXT_AREA_BYTES;
  assign task_switched_o = ctrl0_r[`LFS_TS_BIT];
  assign os_ext_enable_o = ctrl4_r[`LFS_OSX_BIT];
  assign xfe_o = xfe_r;

endmodule : lfs_ctrl

// File: verif/lfs_ctrl_sva.sv
// lfs_ctrl_sva: port-level checks of the lazy state trap and save/restore decisions
// assumes binding onto lfs_ctrl, one clock, active-low reset
`timescale 1ns/1ns
module lfs_ctrl_sva
  import lfs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire lfs_op_e instr_op_i,
  input wire logic [1:0] instr_ring_i,
  input wire logic [63:0] instr_data_i,
  input wire logic [63:0] hdr_bitmap_i,
  input wire logic [127:0] hdr_rsvd_i,
  input wire logic done_o,
  input wire logic nm_fault_o,
  input wire logic gp_fault_o,
  input wire logic [63:0] result_o,
  input wire logic [63:0] store_mask_o,
  input wire logic [63:0] load_mask_o,
  input wire logic [63:0] init_mask_o,
  input wire logic [63:0] bitmap_o,
  input wire logic task_switched_o,
  input wire logic os_ext_enable_o,
  input wire logic [63:0] xfe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  a_fp_traps: assert property (
    instr_valid_i && task_switched_o && instr_op_i inside {LFS_OP_FPVEC, LFS_OP_PACKED_INT}
    |=> done_o && nm_fault_o) else $error("fp op not trapped");
  a_gpr_no_trap: assert property (
    instr_valid_i && instr_op_i inside {LFS_OP_CRC, LFS_OP_POPULATION_COUNT_INSTR}
    |=> done_o && !nm_fault_o && !gp_fault_o) else $error("gpr op faulted");
  a_switch_sets: assert property (
    instr_valid_i && instr_op_i == LFS_OP_TASK_SWITCH |=> task_switched_o)
    else $error("task switch left flag clear");
  a_cr0_flag: assert property (
    instr_valid_i && instr_op_i == LFS_OP_MOV_CR0 && instr_ring_i == 2'b00
    |=> task_switched_o == $past(instr_data_i[3])) else $error("flag not from bit 3");
  a_clear_task_switched_instr_clears: assert property (
    instr_valid_i && instr_op_i == LFS_OP_CLEAR_TASK_SWITCHED_INSTR && instr_ring_i == 2'b00
    |=> !task_switched_o) else $error("flag not cleared");
  a_feature_bits: assert property (
    instr_valid_i && instr_op_i == LFS_OP_FEATURE_ID && instr_data_i[31:0] == 32'h0000_0001
    |=> result_o[26] && result_o[27] == $past(os_ext_enable_o)) else $error("feature bits");
  a_os_enable: assert property (
    instr_valid_i && instr_op_i == LFS_OP_MOV_CR4 && instr_ring_i == 2'b00
    |=> os_ext_enable_o == $past(instr_data_i[18])) else $error("os enable not bit 18");
  a_xfe_guard: assert property (
    instr_valid_i && instr_op_i == LFS_OP_XFE_WRITE && (instr_ring_i != 2'b00 || !instr_data_i[0])
    |=> gp_fault_o && $stable(xfe_o)) else $error("bad enable write accepted");
  a_bitmap_match: assert property (
    done_o |-> bitmap_o == store_mask_o) else $error("bitmap differs from stored set");
  a_save_mask: assert property (
    instr_valid_i && instr_op_i == LFS_OP_SAVE && !task_switched_o
    |=> store_mask_o == ($past(instr_data_i) & $past(xfe_o))) else $error("save set wrong");
  a_restore_split: assert property (
    instr_valid_i && instr_op_i == LFS_OP_RESTORE && !task_switched_o && hdr_rsvd_i == '0
    |=> load_mask_o == ($past(instr_data_i) & $past(xfe_o) & $past(hdr_bitmap_i))
    ##0 init_mask_o == ($past(instr_data_i) & $past(xfe_o) & ~$past(hdr_bitmap_i)))
    else $error("restore split wrong");
  a_rsvd_gp: assert property (
    instr_valid_i && instr_op_i == LFS_OP_RESTORE && !task_switched_o && hdr_rsvd_i != '0
    |=> gp_fault_o) else $error("reserved header accepted");
  a_nm_precise: assert property (
    nm_fault_o |-> result_o == '0 && store_mask_o == '0 && load_mask_o == '0 &&
    init_mask_o == '0 && $stable(xfe_o))
    else $error("trap changed state");
endmodule : lfs_ctrl_sva

bind lfs_ctrl lfs_ctrl_sva u_sva (.clock_i(clock_i), .rstn_i(rstn_i),
  .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_ring_i(instr_ring_i),
  .instr_data_i(instr_data_i), .hdr_bitmap_i(hdr_bitmap_i), .hdr_rsvd_i(hdr_rsvd_i),
  .done_o(done_o), .nm_fault_o(nm_fault_o), .gp_fault_o(gp_fault_o), .result_o(result_o),
  .store_mask_o(store_mask_o), .load_mask_o(load_mask_o), .init_mask_o(init_mask_o),
  .bitmap_o(bitmap_o), .task_switched_o(task_switched_o), .os_ext_enable_o(os_ext_enable_o),
  .xfe_o(xfe_o));

// File: verif/testbench.sv
// testbench: drives instructions and the register bus of lfs_ctrl, checks answers from queues
// assumes lfs_ctrl with the parameters set below and the bound checker
`timescale 1ns/1ns
`include "lfs_params.svh"
module testbench
  import lfs_pkg::*;
;
  localparam logic [63:0] XS = 64'h0000_0000_0000_0003;
  localparam logic [31:0] AB = `LFS_LEGACY_BYTES + `LFS_HDR_BYTES + 32'h0000_0100;
  logic clock_i = 0, rstn_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, iv = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0;
  lfs_op_e op = LFS_OP_NONE;
  logic [1:0] ring = 0;
  logic [63:0] idata = 0, hbm = 0, m, b;
  logic [127:0] hrs = 0;
  logic awready, wready, bvalid, arready, rvalid, done, nm, gp, ts, ose;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, abytes;
  logic [63:0] res, stm, ldm, inm, bmp, xfe;
  logic [321:0] iq[$];
  logic [33:0] aq[$];
  lfs_op_e ops[6] = '{LFS_OP_FPVEC, LFS_OP_PACKED_INT, LFS_OP_CRC, LFS_OP_POPULATION_COUNT_INSTR,
    LFS_OP_SAVE, LFS_OP_RESTORE};
  int n_mismatch = 0, total_checks = 0, seed = 78;

  lfs_ctrl #(.ADDR_W(8), .EXT_STATE_SAVE_INSTR_SUPPORTED(1'b1), .XFE_SUPPORTED(XS),
    .EXT_AREA_BYTES(32'h0000_0100)) dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(addr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(addr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .instr_valid_i(iv),
    .instr_op_i(op), .instr_ring_i(ring), .instr_data_i(idata), .hdr_bitmap_i(hbm),
    .hdr_rsvd_i(hrs), .done_o(done), .nm_fault_o(nm), .gp_fault_o(gp), .result_o(res),
    .store_mask_o(stm), .load_mask_o(ldm), .init_mask_o(inm), .bitmap_o(bmp),
    .area_bytes_o(abytes), .task_switched_o(ts), .os_ext_enable_o(ose), .xfe_o(xfe));

  task automatic chk(input logic [321:0] got, input logic [321:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [321:0] ex(logic n, logic g, logic [63:0] r, logic [63:0] s,
    logic [63:0] l = 0, logic [63:0] i = 0);
    return {n, g, r, s, l, i, s};
  endfunction : ex

  task automatic ins(lfs_op_e o, logic [1:0] r, logic [63:0] d, logic [321:0] e,
    logic [63:0] bm = 0, logic [127:0] h = 0);
    @(posedge clock_i);
    iv <= 1;
    op <= o;
    ring <= r;
    idata <= d;
    hbm <= bm;
    hrs <= h;
    iq.push_back(e);
  endtask : ins

  task automatic idle();
    @(posedge clock_i);
    iv <= 0;
    @(posedge clock_i);
  endtask : idle

  // one bus transfer; the monitor compares the response
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
    int n = 0;
    @(posedge clock_i);
    aq.push_back(e);
    addr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do
    begin
      @(posedge clock_i);
      n++;
      if (awready === 1'b1)
        awvalid <= 0;
      if (wready === 1'b1)
        wvalid <= 0;
      if (arready === 1'b1)
        arvalid <= 0;
    end while (!((bvalid && bready) === 1'b1 || (rvalid && rready) === 1'b1) && n < 50);
    bready <= 0;
    rready <= 0;
    if (n >= 50)
      n_mismatch++;
  endtask : bus

  task automatic wrap_up();
    if (iq.size() != 0 || aq.size() != 0)
      n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  always @(posedge clock_i)
  begin
    if (done === 1'b1)
      chk({nm, gp, res, stm, ldm, inm, bmp}, iq.pop_front());
    if ((bvalid && bready) === 1'b1)
      chk({bresp, 32'h0}, aq.pop_front());
    if ((rvalid && rready) === 1'b1)
      chk({rresp, rdata}, aq.pop_front());
  end

  initial
  begin
    forever #2 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1;
    bus(0, `LFS_OFF_CTRL0, 0, {`LFS_RESP_OKAY, `LFS_CTRL0_RST});
    bus(0, `LFS_OFF_XFE_LO, 0, {`LFS_RESP_OKAY, 32'h0000_0001});
    bus(0, 8'h18, 0, {`LFS_RESP_SLVERR, 32'h0});
    bus(1, `LFS_OFF_XFE_LO, 32'h0000_0002, {`LFS_RESP_SLVERR, 32'h0});
    bus(1, `LFS_OFF_CTRL4, 32'h0004_0000, {`LFS_RESP_OKAY, 32'h0});
    bus(0, `LFS_OFF_CTRL4, 0, {`LFS_RESP_OKAY, 32'h0004_0000});
    for (int k = 0; k < 2; k++)
    begin
      ins(LFS_OP_MOV_CR4, 0, 64'(k) << 18, ex(0, 0, 0, 0));
      ins(LFS_OP_FEATURE_ID, 3, 1, ex(0, 0, (64'(k) << 27) | 64'h0400_0000, 0));
      idle();
      chk(ose, k[0]);
    end
    ins(LFS_OP_FEATURE_ID, 3, `LFS_LEAF_XSTATE, ex(0, 0, {XS[31:0], AB}, 0));
    ins(LFS_OP_XFE_WRITE, 3, 3, ex(0, 1, 0, 0));
    ins(LFS_OP_XFE_WRITE, 0, 2, ex(0, 1, 0, 0));
    ins(LFS_OP_XFE_WRITE, 0, 3, ex(0, 0, 0, 0));
    ins(LFS_OP_XFE_READ, 3, 0, ex(0, 0, XS, 0));
    ins(LFS_OP_MOV_CR0, 1, 8, ex(0, 1, 0, 0));
    ins(LFS_OP_MOV_CR0, 0, 8, ex(0, 0, 0, 0));
    for (int k = 0; k < 6; k++)
      ins(ops[k], 0, 3, ex(k < 2 || k > 3, 0, 0, 0));
    ins(LFS_OP_CLEAR_TASK_SWITCHED_INSTR, 0, 0, ex(0, 0, 0, 0));
    idle();
    chk(ts, 0);
    ins(LFS_OP_FPVEC, 0, 0, ex(0, 0, 0, 0));
    ins(LFS_OP_TASK_SWITCH, 2, 0, ex(0, 0, 0, 0));
    idle();
    chk(ts, 1);
    ins(LFS_OP_MOV_CR0, 0, 0, ex(0, 0, 0, 0));
    ins(LFS_OP_RESTORE, 0, 3, ex(0, 1, 0, 0), 0, 128'h1);
    repeat (24)
    begin
      m = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      ins(LFS_OP_SAVE, 0, m, ex(0, 0, 0, m & XS));
      ins(LFS_OP_RESTORE, 0, m, ex(0, 0, 0, 0, m & b & XS, m & ~b & XS), b);
    end
    idle();
    chk(xfe, XS);
    chk(abytes, AB);
    bus(0, `LFS_OFF_FAULTS, 0, {`LFS_RESP_OKAY, 32'h0004_0004});
    bus(0, `LFS_OFF_BITMAP, 0, {`LFS_RESP_OKAY, m[31:0] & XS[31:0]});
    // let the monitor take the last answer before the queues are judged
    repeat (2) @(posedge clock_i);
    wrap_up();
  end
endmodule : testbench
